// ==== shared/fpc_regs.svh ====
// named constants of the front-panel parameter control block
// assumes a 100 MHz system clock; included by bare name
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH

// clock rate and panel timings, each in its own unit
`define FPC_CLK_MHZ     100
`define FPC_REPEAT_MS   300
`define FPC_FLASH_MS    1000
`define FPC_ERR_MS      1000
`define FPC_MS_TO_US    1000
`define FPC_TMR_W       28

// reference mode/range positions: six internal, then F and double rate
`define FPC_REF_LAST_INT 3'h5
`define FPC_REF_EXT_F    3'h6
`define FPC_REF_LAST     3'h7
`define FPC_REF_RST      3'h6

// internal frequency in tenths of a percent of range full scale
`define FPC_FREQ_MAX     10'h3E8
`define FPC_FREQ_FINE    10'h001
`define FPC_FREQ_COARSE  10'h00A
`define FPC_FREQ_RST     10'h064
`define FPC_FAST_AFTER   4'hA

// phase in 0.025 degree units; fine range biased by 2.5 degrees
`define FPC_PH_STEP_S    12'h001
`define FPC_PH_STEP_M    12'h004
`define FPC_PH_STEP_L    12'h028
`define FPC_PH_MID_STEPS 4'h9
`define FPC_PH_MAX       12'hED8
`define FPC_PH_RST       12'h064
`define FPC_PH_QUAD      16'h0E10
`define FPC_QUAD_MAX     2'h3

// time constant index 1 ms .. 100 s in 1-3-10 order
`define FPC_TC_MAX       4'hA
`define FPC_TC_RST       4'h6

// sensitivity index 1 uV .. 5 V in 1-2-5 order
`define FPC_SENS_MAX     5'h14
`define FPC_SENS_RST     5'h0F
`define FPC_STAB_MIN     5'h06
`define FPC_NORM_MIN     5'h03
`define FPC_NORM_MAX     5'h0E
`define FPC_MAXR_MAX     5'h0B
`define FPC_EXP_SHIFT    5'h03
`define FPC_LIMIT_RST    5'h00

`endif

// ==== shared/fpc_pkg.sv ====
// types shared by the front-panel parameter control block
// assumes the constants header fpc_regs.svh alongside
package fpc_pkg;

  // select-key function that the step keys act on
  typedef enum logic [1:0] {
    FPC_F_REF   = 2'b00,
    FPC_F_PHASE = 2'b01,
    FPC_F_TC    = 2'b10,
    FPC_F_SENS  = 2'b11
  } fpc_func_e;

  // dynamic reserve settings
  typedef enum logic [1:0] {
    FPC_RES_STAB = 2'b00,
    FPC_RES_NORM = 2'b01,
    FPC_RES_MAX  = 2'b10
  } fpc_res_e;

  // keypad levels, high while held
  typedef struct packed {
    logic refSel;
    logic phaseSel;
    logic tcSel;
    logic sensSel;
    logic up;
    logic down;
  } fpc_keys_s;

  // sub-state indicators, one pair per select key
  typedef struct packed {
    logic refRange;
    logic refFreq;
    logic phFine;
    logic phQuad;
    logic tcValue;
    logic tcSlope;
    logic sensSet;
    logic sensLimit;
  } fpc_leds_s;

  // parameter settings as driven to the instrument
  typedef struct packed {
    logic [2:0]  refPos;
    logic        refInternal;
    logic        refDouble;
    logic [9:0]  freq;
    logic [1:0]  quad;
    logic [15:0] phaseAdv;
    logic [3:0]  tc;
    logic        slope12;
    logic [4:0]  sens;
    logic [4:0]  limit;
    logic [4:0]  ch1Eff;
    logic [4:0]  ch2Eff;
    fpc_res_e    reserve;
  } fpc_set_s;

endpackage : fpc_pkg

// ==== src/fpc_key_repeat.sv ====
// held-key auto-repeat: one step on press, then one per repeat interval
// assumes a synchronous key level and the 100 MHz system clock
`include "fpc_regs.svh"
module fpc_key_repeat #(
  parameter int REPEAT_CYC = `FPC_REPEAT_MS * `FPC_CLK_MHZ * `FPC_MS_TO_US
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // key level
  input  wire logic       keyHeld,
  // step output
  output logic            stepPulse,
  output logic [3:0]      stepIdx
);

  logic                  keyPrev_r;  // key level one cycle ago
  logic [3:0]            done_r;     // steps made in this hold
  logic [`FPC_TMR_W-1:0] tmr_r;      // repeat interval timer

  // step timing; index saturates so long holds stay in the fast band
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      keyPrev_r <= 1'b0;
      done_r    <= 4'h0;
      tmr_r     <= '0;
      stepPulse <= 1'b0;
      stepIdx   <= 4'h0;
    end
    else
    begin
      keyPrev_r <= keyHeld;
      stepPulse <= 1'b0;
      if (keyHeld && !keyPrev_r)
      begin
        // press: immediate first step
        stepPulse <= 1'b1;
        stepIdx   <= 4'h0;
        done_r    <= 4'h1;
        tmr_r     <= '0;
      end
      else if (keyHeld)
      begin
        // held: next step after a full interval
        if (tmr_r == `FPC_TMR_W'(REPEAT_CYC - 1))
        begin
          stepPulse <= 1'b1;
          stepIdx   <= done_r;
          tmr_r     <= '0;
          if (done_r != 4'hF)
            done_r <= done_r + 4'h1;
        end
        else
          tmr_r <= tmr_r + `FPC_TMR_W'(1);
      end
      else
        tmr_r <= '0;
    end
  end

endmodule : fpc_key_repeat

// ==== src/fpc_panel_ctrl.sv ====
// front-panel parameter control: select keys, step keys, settings, LEDs
// assumes synchronous keypad levels and one 100 MHz clock domain
//
// Behaviour
// - reference key toggles range and frequency indicators
// - six internal ranges, then two external positions
// - internal mode without oscillator card shows error
// - external modes run at F or double F
// - frequency steps are 0.1% of range top
// - after ten steps frequency steps become 1%
// - phase key toggles fine and quadrant indicators
// - four quadrants, each overlapping 2.5 degrees
// - fine phase steps 0.025, nine 0.1, then 1
// - phase shown as reference advance degrees
// - time-constant key toggles value and slope
// - time constant 1 ms to 100 s, 1-3-10
// - slope is 6 or 12 dB per octave
// - sensitivity key toggles set and autorange ceiling
// - expand makes channel one ten times sensitive
// - expand never touches channel two span
// - reserve limits the allowed sensitivity span
// - conflicting sensitivity moves reserve, flashes reserve
// - conflicting reserve refused, sensitivity LED flashes
// - ceiling bounds autorange only, not manual
// - shared up and down keys act on active function
`include "fpc_regs.svh"
module fpc_panel_ctrl #(
  parameter int REPEAT_CYC = `FPC_REPEAT_MS * `FPC_CLK_MHZ * `FPC_MS_TO_US,
  parameter int FLASH_CYC  = `FPC_FLASH_MS * `FPC_CLK_MHZ * `FPC_MS_TO_US,
  parameter int ERR_CYC    = `FPC_ERR_MS * `FPC_CLK_MHZ * `FPC_MS_TO_US
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // keypad
  input  fpc_pkg::fpc_keys_s     keys,
  // fitted options and neighbouring controls
  input  wire logic              oscCardPresent,
  input  wire logic              expandOn,
  input  wire logic              reserveReq,
  input  fpc_pkg::fpc_res_e      reserveReqVal,
  input  wire logic              autoRangeUp,
  input  wire logic              autoRangeDown,
  // indicators and messages
  output fpc_pkg::fpc_leds_s     leds,
  output logic                   missingCardError,
  output logic                   reserveFlash,
  output logic                   sensFlash,
  // settings
  output fpc_pkg::fpc_set_s      settings
);

  // select-key edge detection
  fpc_pkg::fpc_keys_s     keysPrev_r;    // key levels one cycle ago
  logic                   refPress;      // reference key pressed
  logic                   phPress;       // phase key pressed
  logic                   tcPress;       // time-constant key pressed
  logic                   sensPress;     // sensitivity key pressed

  // step keys
  logic                   upStep;        // up key step pulse
  logic                   dnStep;        // down key step pulse
  logic [3:0]             upIdx;         // up step number in hold
  logic [3:0]             dnIdx;         // down step number in hold
  logic                   step;          // exactly one key stepped
  logic                   dirUp;         // direction of that step
  logic [3:0]             stepIdx;       // its number in the hold

  // control state
  fpc_pkg::fpc_func_e     func_r;        // active select function
  logic                   refSub_r;      // 1: frequency adjust
  logic                   phSub_r;       // 1: quadrant select
  logic                   tcSub_r;       // 1: slope select
  logic                   sensSub_r;     // 1: autorange ceiling

  // parameter settings
  logic [2:0]             refPos_r;      // range / external position
  logic [9:0]             freq_r;        // frequency in 0.1% units
  logic [1:0]             quad_r;        // phase quadrant
  logic [11:0]            fine_r;        // fine phase, biased
  logic [3:0]             tc_r;          // time constant index
  logic                   slope12_r;     // 12 dB per octave
  logic [4:0]             sens_r;        // sensitivity index
  logic [4:0]             limit_r;       // autorange ceiling index
  fpc_pkg::fpc_res_e      reserve_r;     // dynamic reserve

  // sensitivity change of this cycle
  logic [4:0]             sens_nxt;      // requested sensitivity
  logic                   sensChg;       // a change was requested

  // message timers
  logic [`FPC_TMR_W-1:0]  errTmr_r;      // error message time left
  logic [`FPC_TMR_W-1:0]  resTmr_r;      // reserve flash time left
  logic [`FPC_TMR_W-1:0]  sensTmr_r;     // sensitivity flash time left
  logic                   refGoInt;      // step lands on internal range

  // reserve allows this sensitivity index
  function automatic logic resAllows(input fpc_pkg::fpc_res_e res,
                                     input logic [4:0] s);
    case (res)
      fpc_pkg::FPC_RES_STAB: resAllows = (s >= `FPC_STAB_MIN);
      fpc_pkg::FPC_RES_NORM: resAllows = (s >= `FPC_NORM_MIN) &&
                                         (s <= `FPC_NORM_MAX);
      default:               resAllows = (s <= `FPC_MAXR_MAX);
    endcase
  endfunction : resAllows

  // reserve that fits a sensitivity index
  function automatic fpc_pkg::fpc_res_e resFit(input logic [4:0] s);
    if (s > `FPC_NORM_MAX)
      resFit = fpc_pkg::FPC_RES_STAB;
    else if (s < `FPC_NORM_MIN)
      resFit = fpc_pkg::FPC_RES_MAX;
    else
      resFit = fpc_pkg::FPC_RES_NORM;
  endfunction : resFit

  // auto-repeat for each step key
  fpc_key_repeat #(
    .REPEAT_CYC (REPEAT_CYC)
  ) upRepeat (
    .clk       (clk),
    .rst       (rst),
    .keyHeld   (keys.up),
    .stepPulse (upStep),
    .stepIdx   (upIdx)
  );

  fpc_key_repeat #(
    .REPEAT_CYC (REPEAT_CYC)
  ) dnRepeat (
    .clk       (clk),
    .rst       (rst),
    .keyHeld   (keys.down),
    .stepPulse (dnStep),
    .stepIdx   (dnIdx)
  );

  // press edges and the single step of this cycle
  assign refPress  = keys.refSel   && !keysPrev_r.refSel;
  assign phPress   = keys.phaseSel && !keysPrev_r.phaseSel;
  assign tcPress   = keys.tcSel    && !keysPrev_r.tcSel;
  assign sensPress = keys.sensSel  && !keysPrev_r.sensSel;
  assign step      = upStep ^ dnStep;   // both at once cancel
  assign dirUp     = upStep;
  assign stepIdx   = upStep ? upIdx : dnIdx;
  assign refGoInt  = step && (func_r == fpc_pkg::FPC_F_REF) && !refSub_r &&
                     (dirUp ? (refPos_r < `FPC_REF_LAST_INT)
                            : (refPos_r != 3'h0) &&
                              (refPos_r <= `FPC_REF_EXT_F));

  // key history
  always_ff @(posedge clk)
  begin
    if (rst)
      keysPrev_r <= '0;
    else
      keysPrev_r <= keys;
  end

  // active function and sub-state toggles
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      func_r    <= fpc_pkg::FPC_F_REF;
      refSub_r  <= 1'b0;
      phSub_r   <= 1'b0;
      tcSub_r   <= 1'b0;
      sensSub_r <= 1'b0;
    end
    else if (refPress)
    begin
      func_r   <= fpc_pkg::FPC_F_REF;
      refSub_r <= !refSub_r;
    end
    else if (phPress)
    begin
      func_r  <= fpc_pkg::FPC_F_PHASE;
      phSub_r <= !phSub_r;
    end
    else if (tcPress)
    begin
      func_r  <= fpc_pkg::FPC_F_TC;
      tcSub_r <= !tcSub_r;
    end
    else if (sensPress)
    begin
      func_r    <= fpc_pkg::FPC_F_SENS;
      sensSub_r <= !sensSub_r;
    end
  end

  // reference position and internal frequency
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      refPos_r <= `FPC_REF_RST;
      freq_r   <= `FPC_FREQ_RST;
    end
    else if (step && func_r == fpc_pkg::FPC_F_REF)
    begin
      if (!refSub_r)
      begin
        // internal ranges first, then the two external modes
        if (dirUp && refPos_r != `FPC_REF_LAST)
          refPos_r <= refPos_r + 3'h1;
        else if (!dirUp && refPos_r != 3'h0)
          refPos_r <= refPos_r - 3'h1;
      end
      else if (stepIdx < `FPC_FAST_AFTER)
      begin
        // fine steps of 0.1% of range top
        if (dirUp)
          freq_r <= (freq_r > `FPC_FREQ_MAX - `FPC_FREQ_FINE) ?
                    `FPC_FREQ_MAX : freq_r + `FPC_FREQ_FINE;
        else
          freq_r <= (freq_r < `FPC_FREQ_FINE) ?
                    10'h000 : freq_r - `FPC_FREQ_FINE;
      end
      else
      begin
        // coarse steps of 1% once ten steps were made
        if (dirUp)
          freq_r <= (freq_r > `FPC_FREQ_MAX - `FPC_FREQ_COARSE) ?
                    `FPC_FREQ_MAX : freq_r + `FPC_FREQ_COARSE;
        else
          freq_r <= (freq_r < `FPC_FREQ_COARSE) ?
                    10'h000 : freq_r - `FPC_FREQ_COARSE;
      end
    end
  end

  // missing oscillator card message
  always_ff @(posedge clk)
  begin
    if (rst)
      errTmr_r <= '0;
    else if (refGoInt && !oscCardPresent)
      errTmr_r <= `FPC_TMR_W'(ERR_CYC);
    else if (errTmr_r != '0)
      errTmr_r <= errTmr_r - `FPC_TMR_W'(1);
  end

  // phase quadrant and fine phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      quad_r <= 2'h0;
      fine_r <= `FPC_PH_RST;
    end
    else if (step && func_r == fpc_pkg::FPC_F_PHASE)
    begin
      if (phSub_r)
      begin
        // one of four quadrants
        if (dirUp && quad_r != `FPC_QUAD_MAX)
          quad_r <= quad_r + 2'h1;
        else if (!dirUp && quad_r != 2'h0)
          quad_r <= quad_r - 2'h1;
      end
      else
      begin
        // step size grows with the hold: small, medium, large
        logic [11:0] inc;
        inc = `FPC_PH_STEP_L;
        if (stepIdx == 4'h0)
          inc = `FPC_PH_STEP_S;
        else if (stepIdx <= `FPC_PH_MID_STEPS)
          inc = `FPC_PH_STEP_M;
        // fine range spans 2.5 degrees beyond each boundary
        if (dirUp)
          fine_r <= (fine_r > `FPC_PH_MAX - inc) ?
                    `FPC_PH_MAX : fine_r + inc;
        else
          fine_r <= (fine_r < inc) ? 12'h000 : fine_r - inc;
      end
    end
  end

  // time constant and rolloff slope
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tc_r      <= `FPC_TC_RST;
      slope12_r <= 1'b0;
    end
    else if (step && func_r == fpc_pkg::FPC_F_TC)
    begin
      if (tcSub_r)
        slope12_r <= dirUp;
      else if (dirUp && tc_r != `FPC_TC_MAX)
        tc_r <= tc_r + 4'h1;
      else if (!dirUp && tc_r != 4'h0)
        tc_r <= tc_r - 4'h1;
    end
  end

  // requested sensitivity: manual first, autorange otherwise
  always_comb
  begin
    sens_nxt = sens_r;
    sensChg  = 1'b0;
    if (step && func_r == fpc_pkg::FPC_F_SENS && !sensSub_r)
    begin
      // manual change ignores the ceiling
      if (dirUp && sens_r != `FPC_SENS_MAX)
      begin
        sens_nxt = sens_r + 5'h01;
        sensChg  = 1'b1;
      end
      else if (!dirUp && sens_r != 5'h00)
      begin
        sens_nxt = sens_r - 5'h01;
        sensChg  = 1'b1;
      end
    end
    else if (autoRangeUp && !autoRangeDown && sens_r != `FPC_SENS_MAX)
    begin
      sens_nxt = sens_r + 5'h01;
      sensChg  = 1'b1;
    end
    else if (autoRangeDown && !autoRangeUp && sens_r > limit_r)
    begin
      // autorange never goes more sensitive than the ceiling
      sens_nxt = sens_r - 5'h01;
      sensChg  = 1'b1;
    end
  end

  // sensitivity and autorange ceiling
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sens_r  <= `FPC_SENS_RST;
      limit_r <= `FPC_LIMIT_RST;
    end
    else
    begin
      sens_r <= sens_nxt;
      if (step && func_r == fpc_pkg::FPC_F_SENS && sensSub_r)
      begin
        if (dirUp && limit_r != `FPC_SENS_MAX)
          limit_r <= limit_r + 5'h01;
        else if (!dirUp && limit_r != 5'h00)
          limit_r <= limit_r - 5'h01;
      end
    end
  end

  // reserve: sensitivity dominates, reserve requests are checked
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reserve_r <= fpc_pkg::FPC_RES_STAB;
      resTmr_r  <= '0;
      sensTmr_r <= '0;
    end
    else
    begin
      if (resTmr_r != '0)
        resTmr_r <= resTmr_r - `FPC_TMR_W'(1);
      if (sensTmr_r != '0)
        sensTmr_r <= sensTmr_r - `FPC_TMR_W'(1);
      if (sensChg && !resAllows(reserve_r, sens_nxt))
      begin
        // move reserve to fit and flash it
        reserve_r <= resFit(sens_nxt);
        resTmr_r  <= `FPC_TMR_W'(FLASH_CYC);
      end
      else if (reserveReq && !sensChg)
      begin
        if (resAllows(reserveReqVal, sens_r))
          reserve_r <= reserveReqVal;
        else
          sensTmr_r <= `FPC_TMR_W'(FLASH_CYC);
      end
    end
  end

  // indicators and messages, registered
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      leds             <= '0;
      missingCardError <= 1'b0;
      reserveFlash     <= 1'b0;
      sensFlash        <= 1'b0;
    end
    else
    begin
      // exactly one LED of each pair
      leds.refRange    <= !refSub_r;
      leds.refFreq     <= refSub_r;
      leds.phFine      <= !phSub_r;
      leds.phQuad      <= phSub_r;
      leds.tcValue     <= !tcSub_r;
      leds.tcSlope     <= tcSub_r;
      leds.sensSet     <= !sensSub_r;
      leds.sensLimit   <= sensSub_r;
      missingCardError <= (errTmr_r != '0);
      reserveFlash     <= (resTmr_r != '0);
      sensFlash        <= (sensTmr_r != '0);
    end
  end

  // settings, registered
  always_ff @(posedge clk)
  begin
    if (rst)
      settings <= '0;
    else
    begin
      settings.refPos      <= refPos_r;
      settings.refInternal <= (refPos_r <= `FPC_REF_LAST_INT);
      settings.refDouble   <= (refPos_r == `FPC_REF_LAST);
      settings.freq        <= freq_r;
      settings.quad        <= quad_r;
      // advance = quadrant base + fine - 2.5 degree bias
      settings.phaseAdv    <= 16'(quad_r) * `FPC_PH_QUAD +
                              16'(fine_r) - 16'(`FPC_PH_RST);
      settings.tc          <= tc_r;
      settings.slope12     <= slope12_r;
      settings.sens        <= sens_r;
      settings.limit       <= limit_r;
      // effective span index from 100 nV in 1-2-5 order; expand shifts channel 1
      settings.ch1Eff      <= expandOn ? sens_r : sens_r + `FPC_EXP_SHIFT;
      settings.ch2Eff      <= sens_r + `FPC_EXP_SHIFT;
      settings.reserve     <= reserve_r;
    end
  end

endmodule : fpc_panel_ctrl

// ==== verif/fpc_keypad.sv ====
// keypad model: a person holding panel keys
// assumes the bench picks held keys by mask
module fpc_keypad (
  // clock
  input  wire logic          clk,
  // keys held, refSel in the top bit
  input  wire logic [5:0]    holdMask,
  // key levels to the panel
  output fpc_pkg::fpc_keys_s keys
);
  timeunit 1ns;
  timeprecision 100ps;
  // no key held at power up
  initial keys = '0;
  // key levels move just after the edge; two shared step keys
  always @(posedge clk)
    keys <= #1 fpc_pkg::fpc_keys_s'(holdMask);
endmodule : fpc_keypad

// ==== verif/fpc_panel_ctrl_assertions.sv ====
// checker of the panel control ports
// assumes a bind onto fpc_panel_ctrl
`include "fpc_regs.svh"
module fpc_panel_ctrl_assertions (
  // clock and reset
  input wire logic          clk,
  input wire logic          rst,
  // watched inputs
  input fpc_pkg::fpc_keys_s keys,
  input wire logic          reserveReq,
  // outputs
  input fpc_pkg::fpc_leds_s leds,
  input wire logic          missingCardError,
  input wire logic          reserveFlash,
  input wire logic          sensFlash,
  input fpc_pkg::fpc_set_s  settings
);
  logic live1R; // outputs loaded
  logic live2R; // loaded a cycle ago
  // age since reset release
  always_ff @(posedge clk)
  begin
    live1R <= !rst;
    live2R <= live1R;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // select presses
  sequence refPress; $rose(keys.refSel); endsequence
  sequence phPress; $rose(keys.phaseSel) && !keys.refSel; endsequence
  pair_onehot_a:
    assert property (live1R |-> (leds.refRange ^ leds.refFreq)
      && (leds.phFine ^ leds.phQuad) && (leds.tcValue ^ leds.tcSlope)
      && (leds.sensSet ^ leds.sensLimit)) else $error("led pair");
  ref_toggle_a:
    assert property (refPress |-> ##[1:3] $changed(leds.refFreq))
      else $error("ref toggle");
  phase_toggle_a:
    assert property (phPress |-> ##[1:3] $changed(leds.phQuad))
      else $error("phase toggle");
  ref_mode_a:
    assert property (live1R |-> settings.refInternal ==
      (settings.refPos <= `FPC_REF_LAST_INT) && settings.refDouble ==
      (settings.refPos == `FPC_REF_LAST)) else $error("ref mode");
  card_error_a:
    assert property ($rose(missingCardError) |-> ##[0:2]
      settings.refInternal) else $error("card error");
  ch2_span_a:
    assert property (live2R && $stable(settings.sens) |->
      settings.ch2Eff == settings.sens + `FPC_EXP_SHIFT)
      else $error("ch2 span");
  reserve_fit_a:
    assert property (live2R && $stable(settings.sens) |->
      (settings.reserve == fpc_pkg::FPC_RES_STAB) ?
      settings.sens >= `FPC_STAB_MIN :
      (settings.reserve == fpc_pkg::FPC_RES_NORM) ?
      (settings.sens >= `FPC_NORM_MIN && settings.sens <= `FPC_NORM_MAX)
      : settings.sens <= `FPC_MAXR_MAX) else $error("reserve fit");
  reserve_flash_a:
    assert property (live2R && $changed(settings.reserve) &&
      !$past(reserveReq) && !$past(reserveReq, 2) |-> ##[0:2]
      reserveFlash) else $error("reserve flash");
  sens_flash_a:
    assert property (live2R && $rose(sensFlash) |-> $past(reserveReq)
      || $past(reserveReq, 2) || $past(reserveReq, 3))
      else $error("sens flash");
  tc_bound_a:
    assert property (live1R |-> settings.tc <= `FPC_TC_MAX &&
      settings.freq <= `FPC_FREQ_MAX) else $error("tc bound");
  sens_step_a:
    assert property (live2R && $changed(settings.sens) |->
      settings.sens - $past(settings.sens) == 5'h01 ||
      $past(settings.sens) - settings.sens == 5'h01)
      else $error("sens step");
endmodule : fpc_panel_ctrl_assertions

// ==== verif/tb.sv ====
// bench of the panel control with a keypad model
// assumes short repeat, flash and error counts
`include "fpc_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [5:0] KREF = 6'h20, KPH = 6'h10, KTC = 6'h08;
  localparam logic [5:0] KSENS = 6'h04, KUP = 6'h02, KDN = 6'h01;
  logic               clk = 1'b0;      // system clock
  logic               rst = 1'b1;      // reset
  logic [5:0]         holdMask = 6'h00; // keys held
  fpc_pkg::fpc_keys_s keys;            // keypad levels
  logic               oscCardPresent = 1'b0;
  logic               expandOn = 1'b0;
  logic               reserveReq = 1'b0;
  fpc_pkg::fpc_res_e  reserveReqVal = fpc_pkg::FPC_RES_STAB;
  logic               autoRangeUp = 1'b0;
  logic               autoRangeDown = 1'b0;
  fpc_pkg::fpc_leds_s leds;
  logic               missingCardError, reserveFlash, sensFlash;
  fpc_pkg::fpc_set_s  settings;
  int                 failures = 0, total_checks = 0, cycles = 0;
  // clock
  always #5 clk = ~clk;
  fpc_keypad KEYPAD (.clk, .holdMask, .keys);
  fpc_panel_ctrl #(.REPEAT_CYC(4), .FLASH_CYC(20), .ERR_CYC(20)) DUT (
    .clk, .rst, .keys, .oscCardPresent, .expandOn, .reserveReq,
    .reserveReqVal, .autoRangeUp, .autoRangeDown, .leds,
    .missingCardError, .reserveFlash, .sensFlash, .settings);
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  // value compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // wait edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // one short key tap
  task automatic press(input logic [5:0] m);
    holdMask = m;
    tick(1);
    holdMask = 6'h00;
    tick(6);
  endtask : press
  // hold a key for n cycles
  task automatic holdFor(input logic [5:0] m, input int n);
    holdMask = m;
    tick(n);
    holdMask = 6'h00;
    tick(8);
  endtask : holdFor
  // one-cycle pulse: 0 more, 1 less sensitive, 2 reserve
  task automatic pulseIn(input int w);
    autoRangeDown = (w == 0);
    autoRangeUp = (w == 1);
    reserveReq = (w == 2);
    tick(1);
    {autoRangeDown, autoRangeUp, reserveReq} = 3'h0;
    tick(4);
  endtask : pulseIn
  // phase or frequency as a plain value
  function automatic logic [15:0] field(input bit ph);
    return ph ? settings.phaseAdv : {6'h00, settings.freq};
  endfunction : field
  // hold a step key and judge the size of each step
  task automatic holdWatch(input logic [5:0] m, input bit ph, input int n);
    logic [15:0] prev, want;
    int          w;
    prev = field(ph);
    holdMask = m;
    for (int i = 0; i < n; i++)
    begin
      w = 0;
      while (field(ph) === prev && w < 40)
      begin
        tick(1);
        w++;
      end
      if (ph)
        want = i == 0 ? `FPC_PH_STEP_S : i < 10 ? `FPC_PH_STEP_M :
          `FPC_PH_STEP_L;
      else
        want = i < 10 ? `FPC_FREQ_FINE : `FPC_FREQ_COARSE;
      chk(field(ph) - prev, want);
      prev = field(ph);
    end
    holdMask = 6'h00;
    tick(10);
  endtask : holdWatch
  // reset state
  task automatic t_reset();
    chk(leds, 16'h00AA);
    chk(settings.refPos, `FPC_REF_RST);
    chk(settings.phaseAdv, 16'h0000);
    chk(settings.sens, `FPC_SENS_RST);
  endtask : t_reset
  // reference modes, frequency steps, card error
  task automatic t_ref();
    press(KREF);
    chk(leds[7:6], 2'b01);
    holdWatch(KUP, 1'b0, 12);
    press(KREF);
    chk(leds[7:6], 2'b10);
    press(KUP);
    chk({settings.refPos, settings.refDouble}, 4'hF);
    press(KUP);
    chk(settings.refPos, `FPC_REF_LAST);
    press(KDN);
    chk(settings.refDouble, 1'b0);
    press(KDN);
    chk({settings.refPos, settings.refInternal}, 4'hB);
    chk(missingCardError, 1'b1);
    tick(30);
    chk(missingCardError, 1'b0);
    oscCardPresent = 1'b1;
    press(KDN);
    chk({settings.refPos, missingCardError}, 4'h8);
  endtask : t_ref
  // quadrant and fine phase
  task automatic t_phase();
    press(KPH);
    chk(leds[5:4], 2'b01);
    press(KUP);
    chk(settings.phaseAdv, `FPC_PH_QUAD);
    repeat (4) press(KUP);
    chk(settings.quad, `FPC_QUAD_MAX);
    repeat (4) press(KDN);
    chk(settings.phaseAdv, 16'h0000);
    press(KPH);
    chk(leds[5:4], 2'b10);
    holdWatch(KUP, 1'b1, 12);
  endtask : t_phase
  // slope and time constant
  task automatic t_tc();
    press(KTC);
    chk(leds[3:2], 2'b01);
    repeat (2) press(KUP);
    chk(settings.slope12, 1'b1);
    press(KDN);
    chk(settings.slope12, 1'b0);
    press(KTC);
    holdFor(KUP, 40);
    chk(settings.tc, `FPC_TC_MAX);
    holdFor(KDN, 60);
    chk(settings.tc, 4'h0);
  endtask : t_tc
  // sensitivity, reserve, expand, autorange ceiling
  task automatic t_sens();
    reserveReqVal = fpc_pkg::FPC_RES_NORM;
    pulseIn(2);
    chk({settings.reserve, sensFlash}, 3'b001);
    expandOn = 1'b1;
    tick(3);
    chk(settings.ch1Eff, `FPC_SENS_RST);
    chk(settings.ch2Eff, `FPC_SENS_RST + `FPC_EXP_SHIFT);
    expandOn = 1'b0;
    tick(3);
    chk(settings.ch1Eff, `FPC_SENS_RST + `FPC_EXP_SHIFT);
    press(KSENS);
    chk(leds[1:0], 2'b01);
    press(KUP);
    chk(settings.limit, 5'h01);
    press(KSENS);
    repeat (10) press(KDN);
    chk({settings.sens, settings.reserve, reserveFlash}, 8'h2B);
    repeat (6) pulseIn(0);
    chk({settings.sens, settings.reserve}, 7'h06);
    press(KDN);
    chk(settings.sens, 5'h00);
    pulseIn(1);
    chk(settings.sens, 5'h01);
  endtask : t_sens
  // main sequence
  initial
  begin
    tick(8);
    rst = 1'b0;
    tick(2);
    t_reset();
    t_ref();
    t_phase();
    t_tc();
    t_sens();
    close_out();
  end
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      failures++;
      close_out();
    end
  end
endmodule : tb
bind fpc_panel_ctrl fpc_panel_ctrl_assertions CHK (
  .clk, .rst, .keys, .reserveReq, .leds, .missingCardError,
  .reserveFlash, .sensFlash, .settings);
